// >>> hw/mtp_codec.sv
// manchester line codec with twisted pair pre-emphasis outputs
`timescale 1ns/1ps
// Operation
// - select pin low uses internal codec; high bypasses it to pins.
// - internal mode still copies the mac codec signals to pins.
// - encoding starts with mac data and runs while data keeps coming.
// - each cell sends inverted data first half, true data second.
// - last transition is positive, mid-cell for one, boundary for zero.
// - idle drives both transmit lines to the same level.
// - decoder recovers clock and data only after squelch passes.
// - decoder tolerates received bit edge jitter up to 18 ns.
// - frame end flagged within one and a half bit times.
// - 10 MHz tone on collision pair gives collision to mac.
// - collision aborts the frame being sent; mac retries later.
// - 20 MHz oscillator halved for the 10 MHz bit clock.
// - true and inverted outputs plus copies delayed 50 ns.
module mtp_codec #(
   parameter int FIFO_W = mtp_pkg::FIFO_W,
   parameter int FIFO_DEPTH = mtp_pkg::FIFO_DEPTH
) (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic EXTERNAL_CODEC_SELECT,
   input wire logic MAC_TX_DATA,
   input wire logic MAC_TX_LAST,
   input wire logic MAC_TX_VALID,
   output logic MAC_TX_READY,
   output logic TRANSMIT_BIT_CLOCK,
   output logic TP_TRANSMIT_PAIR_P,
   output logic TP_TRANSMIT_PAIR_N,
   output logic TP_DELAYED_TRANSMIT_PAIR_P,
   output logic TP_DELAYED_TRANSMIT_PAIR_N,
   input wire logic RX_PAIR_LEVEL,
   input wire logic RX_SQUELCH_OK,
   input wire logic COLLISION_INPUT_PAIR,
   input wire logic EXT_RX_CLOCK,
   input wire logic EXT_RX_DATA,
   input wire logic EXT_CARRIER,
   input wire logic EXT_COLLISION,
   output logic OBS_TX_DATA,
   output logic OBS_TX_ENABLE,
   output logic MAC_RX_DATA,
   output logic MAC_RX_STROBE,
   output logic MAC_RX_END,
   output logic MAC_CARRIER,
   output logic MAC_COLLISION
);
   // pin synchronisers
   logic [mtp_pkg::PIN_N-1:0] pins, s1_r, s2_r, s3_r, flt_r, flt_nxt;
   assign pins = {EXT_COLLISION, EXT_CARRIER, EXT_RX_DATA, EXT_RX_CLOCK,
      EXTERNAL_CODEC_SELECT, COLLISION_INPUT_PAIR, RX_SQUELCH_OK,
      RX_PAIR_LEVEL};
   for (genvar i = 0; i < mtp_pkg::PIN_N; i++) begin : g_flt
      // change only once the last two stages agree
      assign flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         flt_r <= '0;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         flt_r <= flt_nxt;
      end
   end
   logic ext_sel, rx_lvl, sq_ok;
   assign ext_sel = flt_r[mtp_pkg::PIN_EXT];
   // a half cell lasts one sample, so line pins skip the agreement filter
   assign rx_lvl = s3_r[mtp_pkg::PIN_RX];
   assign sq_ok = flt_r[mtp_pkg::PIN_SQ];

   // transmit fifo
   logic f_valid, f_ready;
   logic [FIFO_W-1:0] f_data;
   mtp_fifo #(
      .W(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .in_valid(MAC_TX_VALID),
      .in_ready(MAC_TX_READY),
      .in_data({MAC_TX_LAST, MAC_TX_DATA}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // collision translator
   logic cd_edge, col_now;
   logic [2:0] ccnt_r, ccnt_nxt;
   // tone flips every sample, which the agreement filter would swallow
   assign cd_edge = (s2_r[mtp_pkg::PIN_CD] != s3_r[mtp_pkg::PIN_CD]);
   always_comb begin
      ccnt_nxt = ccnt_r;
      if (cd_edge) begin
         ccnt_nxt = mtp_pkg::COL_HOLD_CYC;
      end else if (ccnt_r != 3'h0) begin
         ccnt_nxt = ccnt_r - 3'h1;
      end
      // tone edges every half bit keep the hold alive
      col_now = ext_sel ? flt_r[mtp_pkg::PIN_ECOL] : (ccnt_r != 3'h0);
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         ccnt_r <= 3'h0;
      end else begin
         ccnt_r <= ccnt_nxt;
      end
   end

   // encoder; half_r is the halved oscillator
   mtp_pkg::mtp_enc_t st_r, st_nxt;
   logic half_r, half_nxt, bit_r, bit_nxt, last_r, last_nxt;
   logic line_r, line_nxt, drv_r, drv_nxt, flush_r, flush_nxt;
   always_comb begin
      st_nxt = st_r;
      half_nxt = ~half_r;
      bit_nxt = bit_r;
      last_nxt = last_r;
      line_nxt = line_r;
      drv_nxt = drv_r;
      flush_nxt = flush_r;
      f_ready = 1'b0;
      case (st_r)
         mtp_pkg::ENC_IDLE: begin
            drv_nxt = 1'b0;
            line_nxt = 1'b0;
            if (flush_r) begin
               // drop the rest of an aborted frame
               f_ready = 1'b1;
               if (f_valid && f_data[1]) begin
                  flush_nxt = 1'b0;
               end
            end else if (half_r && f_valid) begin
               f_ready = 1'b1;
               st_nxt = mtp_pkg::ENC_DATA;
               bit_nxt = f_data[0];
               last_nxt = f_data[1];
               line_nxt = ~f_data[0];
               drv_nxt = 1'b1;
            end
         end
         mtp_pkg::ENC_DATA: begin
            if (!half_r) begin
               line_nxt = bit_r;
            end else if (col_now) begin
               st_nxt = mtp_pkg::ENC_TAIL;
               line_nxt = 1'b1;
               flush_nxt = ~last_r;
            end else if (last_r || !f_valid) begin
               // underrun also ends the frame cleanly
               st_nxt = mtp_pkg::ENC_TAIL;
               line_nxt = 1'b1;
            end else begin
               f_ready = 1'b1;
               bit_nxt = f_data[0];
               last_nxt = f_data[1];
               line_nxt = ~f_data[0];
            end
         end
         mtp_pkg::ENC_TAIL: begin
            st_nxt = mtp_pkg::ENC_IDLE;
            drv_nxt = 1'b0;
            line_nxt = 1'b0;
         end
         default: begin
            st_nxt = mtp_pkg::ENC_IDLE;
            drv_nxt = 1'b0;
         end
      endcase
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= mtp_pkg::ENC_IDLE;
         half_r <= 1'b0;
         bit_r <= 1'b0;
         last_r <= 1'b0;
         line_r <= 1'b0;
         drv_r <= 1'b0;
         flush_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         half_r <= half_nxt;
         bit_r <= bit_nxt;
         last_r <= last_nxt;
         line_r <= line_nxt;
         drv_r <= drv_nxt;
         flush_r <= flush_nxt;
      end
   end

   // line drivers; silent when the external codec is chosen
   logic tp_p_r, tp_p_nxt, tp_n_r, tp_n_nxt, tpd_p_r, tpd_n_r;
   logic obs_d_r, obs_d_nxt, obs_en_r, obs_en_nxt;
   always_comb begin
      tp_p_nxt = drv_r && line_r && !ext_sel;
      tp_n_nxt = drv_r && !line_r && !ext_sel;
      obs_d_nxt = bit_r;
      obs_en_nxt = (st_r == mtp_pkg::ENC_DATA);
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         tp_p_r <= 1'b0;
         tp_n_r <= 1'b0;
         tpd_p_r <= 1'b0;
         tpd_n_r <= 1'b0;
         obs_d_r <= 1'b0;
         obs_en_r <= 1'b0;
      end else begin
         tp_p_r <= tp_p_nxt;
         tp_n_r <= tp_n_nxt;
         tpd_p_r <= tp_p_r;
         tpd_n_r <= tp_n_r;
         obs_d_r <= obs_d_nxt;
         obs_en_r <= obs_en_nxt;
      end
   end
   assign TRANSMIT_BIT_CLOCK = half_r;
   assign TP_TRANSMIT_PAIR_P = tp_p_r;
   assign TP_TRANSMIT_PAIR_N = tp_n_r;
   assign TP_DELAYED_TRANSMIT_PAIR_P = tpd_p_r;
   assign TP_DELAYED_TRANSMIT_PAIR_N = tpd_n_r;
   assign OBS_TX_DATA = obs_d_r;
   assign OBS_TX_ENABLE = obs_en_r;

   // decoder: two samples a cell, so jitter hides inside one sample
   logic dec_on_r, dec_nxt, dlvl_r, rx_edge, rx_mid, rx_stop;
   logic [2:0] dcnt_r, dcnt_nxt;
   assign rx_edge = (rx_lvl != dlvl_r);
   always_comb begin
      dec_nxt = dec_on_r;
      dcnt_nxt = dcnt_r;
      rx_mid = 1'b0;
      rx_stop = 1'b0;
      if (!dec_on_r) begin
         if (sq_ok && rx_edge) begin
            dec_nxt = 1'b1;
            dcnt_nxt = 3'h0;
            rx_mid = 1'b1;
         end
      end else if (!sq_ok) begin
         dec_nxt = 1'b0;
         rx_stop = 1'b1;
      end else if (rx_edge && dcnt_r >= mtp_pkg::RX_MID_MIN) begin
         rx_mid = 1'b1;
         dcnt_nxt = 3'h0;
      end else if (!rx_edge && dcnt_r >= mtp_pkg::RX_END_CNT) begin
         dec_nxt = 1'b0;
         rx_stop = 1'b1;
      end else if (dcnt_r != 3'h7) begin
         dcnt_nxt = dcnt_r + 3'h1;
      end
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         dec_on_r <= 1'b0;
         dcnt_r <= 3'h0;
         dlvl_r <= 1'b0;
      end else begin
         dec_on_r <= dec_nxt;
         dcnt_r <= dcnt_nxt;
         dlvl_r <= rx_lvl;
      end
   end

   // mac receive side, internal or external source
   logic rxd_r, rxd_nxt, stb_r, stb_nxt, end_r, end_nxt;
   logic crs_r, crs_nxt, col_r, col_nxt, erxc_r, ecrs_r;
   always_comb begin
      if (ext_sel) begin
         rxd_nxt = flt_r[mtp_pkg::PIN_ERXD];
         stb_nxt = flt_r[mtp_pkg::PIN_ERXC] && !erxc_r;
         end_nxt = !flt_r[mtp_pkg::PIN_ECRS] && ecrs_r;
         crs_nxt = flt_r[mtp_pkg::PIN_ECRS];
      end else begin
         rxd_nxt = rx_mid ? rx_lvl : rxd_r;
         stb_nxt = rx_mid;
         end_nxt = rx_stop;
         crs_nxt = dec_nxt;
      end
      col_nxt = col_now;
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         rxd_r <= 1'b0;
         stb_r <= 1'b0;
         end_r <= 1'b0;
         crs_r <= 1'b0;
         col_r <= 1'b0;
         erxc_r <= 1'b0;
         ecrs_r <= 1'b0;
      end else begin
         rxd_r <= rxd_nxt;
         stb_r <= stb_nxt;
         end_r <= end_nxt;
         crs_r <= crs_nxt;
         col_r <= col_nxt;
         erxc_r <= flt_r[mtp_pkg::PIN_ERXC];
         ecrs_r <= flt_r[mtp_pkg::PIN_ECRS];
      end
   end
   assign MAC_RX_DATA = rxd_r;
   assign MAC_RX_STROBE = stb_r;
   assign MAC_RX_END = end_r;
   assign MAC_CARRIER = crs_r;
   assign MAC_COLLISION = col_r;

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   sequence s_ext2;
      ext_sel ##1 ext_sel;
   endsequence
   property p_ext_quiet;
      s_ext2 |-> !tp_p_r && !tp_n_r;
   endproperty
   a_ext_quiet: assert property (p_ext_quiet)
      else $error("tp pair driven in external mode");
   property p_obs_copy;
      st_r == mtp_pkg::ENC_DATA |=> obs_en_r && obs_d_r == $past(bit_r);
   endproperty
   a_obs_copy: assert property (p_obs_copy)
      else $error("observation copy missing");
   sequence s_cell;
      (line_r == !bit_r) ##1 (line_r == $past(bit_r));
   endsequence
   property p_cell;
      (st_r == mtp_pkg::ENC_DATA && !half_r) |-> s_cell;
   endproperty
   a_cell: assert property (p_cell)
      else $error("bit cell halves wrong");
   property p_tail;
      st_r == mtp_pkg::ENC_TAIL |-> line_r && drv_r ##1 !drv_r;
   endproperty
   a_tail: assert property (p_tail)
      else $error("end of frame not positive");
   property p_idle;
      !drv_r |=> tp_p_r == tp_n_r;
   endproperty
   a_idle: assert property (p_idle)
      else $error("idle lines unequal");
   property p_div;
      1'b1 |=> half_r != $past(half_r);
   endproperty
   a_div: assert property (p_div)
      else $error("bit clock not halved");
   property p_delay;
      1'b1 |=> tpd_p_r == $past(tp_p_r) && tpd_n_r == $past(tp_n_r);
   endproperty
   a_delay: assert property (p_delay)
      else $error("delayed copy not one cycle late");
   property p_squelch;
      !sq_ok && !dec_on_r |=> !dec_on_r;
   endproperty
   a_squelch: assert property (p_squelch)
      else $error("decode without squelch");
   property p_end;
      (dec_on_r && !rx_edge)[*3] |=> !dec_on_r && (ext_sel || MAC_RX_END);
   endproperty
   a_end: assert property (p_end)
      else $error("frame end late");
   property p_col;
      cd_edge && !ext_sel ##1 !ext_sel |=> MAC_COLLISION;
   endproperty
   a_col: assert property (p_col)
      else $error("collision tone not reported");
endmodule // mtp_codec

// >>> hw/mtp_fifo.sv
// transmit bit fifo with registered ready
`timescale 1ns/1ps
module mtp_fifo #(
   parameter int W = 2,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   // depth must be a power of two, pointers wrap freely
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic rdy_r, rdy_nxt, wr, rd;
   assign wr = in_valid && rdy_r;
   assign rd = out_ready && out_valid;
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign in_ready = rdy_r;
   always_comb begin
      wp_nxt = wr ? wp_r + 1'b1 : wp_r;
      rp_nxt = rd ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r;
      if (wr && !rd) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (rd && !wr) begin
         cnt_nxt = cnt_r - 1'b1;
      end
      rdy_nxt = (cnt_nxt != (AW+1)'(DEPTH));
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         rdy_r <= 1'b0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         rdy_r <= rdy_nxt;
      end
   end
   always_ff @(posedge clk) begin
      if (wr) begin
         mem[wp_r] <= in_data;
      end
   end
endmodule // mtp_fifo

// >>> hw/mtp_pkg.sv
// shared constants and types for the line codec front end
package mtp_pkg;
   localparam int OSC_MHZ = 20;
   localparam int BIT_NS = 100;
   localparam int JITTER_NS = 18;
   // end of frame no later than one and a half bit times
   localparam int RX_END_NS = BIT_NS * 3 / 2;
   localparam logic [2:0] RX_END_CNT = 3'(RX_END_NS * OSC_MHZ / 1000 - 1);
   // mid-cell edge expected one bit after the last one
   localparam logic [2:0] RX_MID_MIN = 3'(BIT_NS * OSC_MHZ / 1000 - 1);
   localparam int COL_HOLD_NS = 200;
   localparam logic [2:0] COL_HOLD_CYC = 3'(COL_HOLD_NS * OSC_MHZ / 1000);
   localparam int FIFO_W = 2;
   localparam int FIFO_DEPTH = 32;
   localparam int PIN_RX = 0;
   localparam int PIN_SQ = 1;
   localparam int PIN_CD = 2;
   localparam int PIN_EXT = 3;
   localparam int PIN_ERXC = 4;
   localparam int PIN_ERXD = 5;
   localparam int PIN_ECRS = 6;
   localparam int PIN_ECOL = 7;
   localparam int PIN_N = 8;
   typedef enum logic [1:0] {ENC_IDLE, ENC_DATA, ENC_TAIL} mtp_enc_t;
endpackage

// >>> testbench/manchester_line_codec_unit_tp_front_tb.sv
// self-checking bench for the manchester line codec
`timescale 1ns/1ps
module manchester_line_codec_unit_tp_front_tb;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic ext_sel = 1'b0;
   logic tx_data = 1'b0;
   logic tx_last = 1'b0;
   logic tx_valid = 1'b0;
   logic ext_rx_clk = 1'b0;
   logic ext_rx_d = 1'b0;
   logic ext_crs = 1'b0;
   logic ext_col = 1'b0;
   logic rx_lvl, sq_ok, col_lvl, tx_ready, bit_clk, tp_p, tp_n;
   logic tpd_p, tpd_n, obs_d, obs_en, rx_d, rx_stb, rx_end;
   logic carrier, coll;
   int mismatches = 0;
   int tests_run = 0;
   int up = 0;
   logic [1:0] cap[$];
   logic capture = 1'b0;
   logic ready_low = 1'b0;
   logic obs_seen = 1'b0;
   logic b_q = 1'b0;
   logic [1:0] pn_q = 2'h0;

   // oscillator taken as 20 MHz so that half cells fit one period
   always #25 clk_sys = ~clk_sys;

   mtp_codec i_mtp_codec (.CLK_SYS(clk_sys), .RST_B(rst_b),
      .EXTERNAL_CODEC_SELECT(ext_sel), .MAC_TX_DATA(tx_data),
      .MAC_TX_LAST(tx_last), .MAC_TX_VALID(tx_valid),
      .MAC_TX_READY(tx_ready), .TRANSMIT_BIT_CLOCK(bit_clk),
      .TP_TRANSMIT_PAIR_P(tp_p), .TP_TRANSMIT_PAIR_N(tp_n),
      .TP_DELAYED_TRANSMIT_PAIR_P(tpd_p),
      .TP_DELAYED_TRANSMIT_PAIR_N(tpd_n), .RX_PAIR_LEVEL(rx_lvl),
      .RX_SQUELCH_OK(sq_ok), .COLLISION_INPUT_PAIR(col_lvl),
      .EXT_RX_CLOCK(ext_rx_clk), .EXT_RX_DATA(ext_rx_d),
      .EXT_CARRIER(ext_crs), .EXT_COLLISION(ext_col),
      .OBS_TX_DATA(obs_d), .OBS_TX_ENABLE(obs_en), .MAC_RX_DATA(rx_d),
      .MAC_RX_STROBE(rx_stb), .MAC_RX_END(rx_end),
      .MAC_CARRIER(carrier), .MAC_COLLISION(coll));

   mtp_medium i_mtp_medium (.rx_level(rx_lvl), .squelch_ok(sq_ok),
      .col_level(col_lvl));

   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      up = rst_b ? up + 1 : 0;
      if (up > 2) begin
         check(bit_clk === ~b_q, "bit clock not halved");
         check({tpd_p, tpd_n} === pn_q, "delayed copy");
         if (tx_ready === 1'b0) ready_low = 1'b1;
      end
      if (obs_en === 1'b1) obs_seen = 1'b1;
      if (capture) cap.push_back({tp_p, tp_n});
      b_q = bit_clk;
      pn_q = {tp_p, tp_n};
   end

   // pattern repeated reps times, last flag only on the final bit
   task automatic send(input logic [31:0] bits, input int n,
                       input int reps);
      for (int i = n * reps - 1; i >= 0; i--) begin
         tx_data = bits[i % n];
         tx_last = (i == 0);
         tx_valid = 1'b1;
         do @(posedge clk_sys); while (tx_ready !== 1'b1);
         #2;
      end
      tx_valid = 1'b0;
      tx_last = 1'b0;
   endtask

   task automatic t_tx(input logic [31:0] bits, input int n, input int reps);
      int s;
      logic b;
      cap.delete();
      ready_low = 1'b0;
      obs_seen = 1'b0;
      capture = 1'b1;
      send(bits, n, reps);
      repeat (2 * n * reps + 20) @(posedge clk_sys);
      #2;
      capture = 1'b0;
      s = 0;
      while (s < cap.size() && cap[s] === 2'h0) s++;
      check(s > 0, "idle before frame");
      for (int i = 0; i < n * reps; i++) begin
         b = bits[n - 1 - (i % n)];
         check(cap[s + 2 * i] === {~b, b}, "first half");
         check(cap[s + 2 * i + 1] === {b, ~b}, "second half");
      end
      s = s + 2 * n * reps;
      check(cap[s] === 2'h2, "tail not high");
      check(cap[s + 1] === 2'h0, "no idle after tail");
      check(obs_seen === 1'b1, "no observe copy");
      check(ready_low === (reps > 1), "fifo refusal");
      check(tx_ready === 1'b1, "fifo not drained");
      $display("tx test of %0d bits done", n * reps);
   endtask

   task automatic t_rx(input logic [31:0] bits, input int n, input logic sq);
      logic [31:0] got;
      int cnt;
      int k;
      int last;
      got = 32'h0;
      cnt = 0;
      last = 0;
      fork
         i_mtp_medium.send_rx(bits, n, sq);
      join_none
      for (k = 0; k < 4 * n + 40; k++) begin
         @(posedge clk_sys);
         if (rx_stb === 1'b1) begin
            got = {got[30:0], rx_d};
            cnt++;
            last = k;
            check(carrier === 1'b1, "no carrier with data");
         end
         if (rx_end === 1'b1) break;
      end
      #2;
      check(cnt == (sq ? n : 0), "bit count");
      check(got === (sq ? bits : 32'h0), "decoded data");
      if (sq) check(k > last && k - last <= 4, "frame end late");
      repeat (20) @(posedge clk_sys);
      #2;
      $display("rx test squelch %0d done", sq);
   endtask

   task automatic t_col();
      int k;
      fork
         send(32'hF0F0_3C3C, 32, 1);
      join_none
      repeat (20) @(posedge clk_sys);
      #2;
      fork
         i_mtp_medium.tone(8);
      join_none
      k = 0;
      while (coll !== 1'b1 && k < 10) begin
         @(posedge clk_sys);
         k++;
      end
      check(coll === 1'b1, "collision not raised");
      repeat (8) @(posedge clk_sys);
      // frame would still run here had it not been cut
      for (k = 0; k < 20; k++) begin
         @(posedge clk_sys);
         check({tp_p, tp_n} === 2'h0, "frame not aborted");
      end
      k = 0;
      while (coll !== 1'b0 && k < 20) begin
         @(posedge clk_sys);
         k++;
      end
      check(coll === 1'b0, "collision stuck");
      repeat (40) @(posedge clk_sys);
      #2;
      $display("collision test done");
   endtask

   task automatic t_ext();
      int k;
      ext_sel = 1'b1;
      ext_crs = 1'b1;
      repeat (8) @(posedge clk_sys);
      for (int d = 1; d >= 0; d--) begin
         #2;
         ext_rx_d = d[0];
         ext_rx_clk = 1'b1;
         k = 0;
         while (rx_stb !== 1'b1 && k < 10) begin
            @(posedge clk_sys);
            k++;
         end
         check(rx_stb === 1'b1 && rx_d === d[0], "ext data");
         repeat (3) @(posedge clk_sys);
         #2;
         ext_rx_clk = 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      #2;
      ext_col = 1'b1;
      ext_crs = 1'b0;
      k = 0;
      while (rx_end !== 1'b1 && k < 10) begin
         @(posedge clk_sys);
         k++;
      end
      check(rx_end === 1'b1, "ext frame end");
      check(coll === 1'b1, "ext collision");
      #2;
      ext_col = 1'b0;
      ext_sel = 1'b0;
      repeat (12) @(posedge clk_sys);
      #2;
      $display("bypass test done");
   endtask

   initial begin
      #1_000_000;
      mismatches++;
      complete_run();
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      #2;
      rst_b = 1'b1;
      repeat (4) @(posedge clk_sys);
      #2;
      t_tx(32'hB38F_0E51, 32, 3);
      t_tx(32'h0000_00A6, 8, 1);
      t_rx(32'h0000_B2D3, 16, 1'b1);
      t_rx(32'h0000_00A5, 8, 1'b0);
      t_col();
      t_tx(32'h0000_00C5, 8, 1);
      t_ext();
      complete_run();
   end
endmodule // manchester_line_codec_unit_tp_front_tb

// >>> testbench/mtp_medium.sv
// medium side model: manchester receive stream and collision tone
`timescale 1ns/1ps
module mtp_medium (
   output logic rx_level,
   output logic squelch_ok,
   output logic col_level
);
   initial begin
      rx_level = 1'b0;
      squelch_ok = 1'b0;
      col_level = 1'b0;
   end
   // msb first; mid edges pushed early and late on alternate cells
   task automatic send_rx(input logic [31:0] bits, input int n,
                          input logic sq);
      int j;
      #23;
      squelch_ok = sq;
      for (int i = n - 1; i >= 0; i--) begin
         j = (i % 2) ? mtp_pkg::JITTER_NS : -mtp_pkg::JITTER_NS;
         rx_level = ~bits[i];
         #(50 + j);
         rx_level = bits[i];
         #(50 - j);
      end
      // released line must not keep the last level
      rx_level = ~rx_level;
      #100;
      squelch_ok = 1'b0;
   endtask
   task automatic tone(input int n);
      repeat (n) begin
         col_level = 1'b1;
         #50;
         col_level = 1'b0;
         #50;
      end
   endtask
endmodule // mtp_medium
